// >>> hdl/homing_pkg.sv
/*
  Shared constants, types and carriers of the homing method selector.
  Assumes a dictionary layer that hands over one expedited transfer per request.
*/
`default_nettype none

package homing_pkg;

  // ---------------------------------------------------------------
  // dictionary objects
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_METHOD    = 16'h6098;
  localparam logic [7:0]  SUB_METHOD    = 8'h00;
  localparam logic [15:0] IDX_STORE     = 16'h1010;
  localparam logic [7:0]  SUB_STORE     = 8'h01;
  localparam logic [7:0]  METHOD_RESET  = 8'h00;

  // internal parameter targets
  localparam logic [15:0] PARAM_HOMING_MODE = 16'h046a;  // parameter 1130
  localparam logic [2:0]  PARAM_DATASET     = 3'h5;      // all data sets, ram only

  // transfer answers
  localparam logic [7:0]  CMD_UPLOAD_1B    = 8'h4f;
  localparam logic [7:0]  CMD_DOWNLOAD_ACK = 8'h60;
  localparam logic [7:0]  CMD_ABORT        = 8'h80;
  localparam logic [31:0] ABORT_NO_OBJECT  = 32'h0602_0000;
  localparam logic [31:0] ABORT_RANGE      = 32'h0609_0030;

  // ---------------------------------------------------------------
  // method codes and per-method tables
  // ---------------------------------------------------------------
  localparam logic [7:0]  M_NONE        = 8'h00;
  localparam logic [7:0]  M_LIM_POS     = 8'h02;
  localparam logic [7:0]  M_HSW_LO      = 8'h03;
  localparam logic [7:0]  M_HSW_POS_HI  = 8'h04;
  localparam logic [7:0]  M_HSW_HI      = 8'h06;
  localparam logic [7:0]  M_SCAN_POS_HI = 8'h0a;
  localparam logic [7:0]  M_SCAN_HI     = 8'h0e;
  localparam logic [7:0]  M_DIRECT_LO   = 8'h11;
  localparam logic [7:0]  M_DIRECT_HI   = 8'h1e;
  localparam logic [7:0]  M_DIRECT_OFS  = 8'h10;
  localparam logic [7:0]  M_IDX_NEG     = 8'h21;
  localparam logic [7:0]  M_IDX_POS     = 8'h22;
  localparam logic [7:0]  M_HERE        = 8'h23;
  // bit n set: final approach of base method n runs positive
  localparam logic [15:0] FINAL_POS_MASK  = 16'h2d32;
  // bit n set: base method n homes on the right switch edge
  localparam logic [15:0] RIGHT_EDGE_MASK = 16'h1e00;

  typedef enum logic [2:0] {K_NONE, K_LIM, K_HSW, K_SCAN, K_IDX, K_HERE, K_BAD} kind_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SEEK, ST_FINE} run_state_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [7:0]  data;
  } dict_req_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  cmd;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] data;
  } dict_rsp_t;

endpackage

`default_nettype wire

// >>> hdl/pin_sync.sv
/*
  Two-stage synchroniser for a group of level inputs.
  Assumes inputs are quasi-static pins; pulses shorter than one clock may be lost.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  // pins and synchronised copy
  input  wire logic [WIDTH-1:0] pins_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // ---------------------------------------------------------------
  // first stage feeds the second only
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= pins_in;
      sync_out <= meta_r;
    end
  end

endmodule

`default_nettype wire

// >>> hdl/homing_method_selector.sv
/*
  Homing method selector: holds the method object, mirrors it into the
  ram parameter, commits it on store, restores it at power-up, and runs
  the reference-run sequence chosen by it.
  Assumes a dictionary layer on the same clock, a non-volatile store that
  presents its saved byte at reset release, and a drive that follows the
  move commands.
*/
// How it works
// [RL1] signed byte method object, reset value zero
// [RL2] each accepted write mirrors into ram parameter
// [RL3] store command commits method to non-volatile memory
// [RL4] stored method restored at power-up, overrides parameter
// [RL5] method 0: no run, position untouched
// [RL6] methods 1,2: limit switch, then index pulse
// [RL7] methods 3-6: home switch edge, then index
// [RL8] methods 7-10: search positive, reverse at limit
// [RL9] methods 11-14: search negative, reverse at limit
// [RL10] methods 17-30: as 1-14, no index pulse
// [RL11] methods 33,34: first index negative or positive
// [RL12] method 35: load home offset as position
// [RL13] one-byte expedited reads and writes, answered
// [RL14] undefined method values rejected, stored unchanged
`timescale 1ns/1ps
`default_nettype none

module homing_method_selector (
  // clock and reset
  input  wire logic                   mclk_in,
  input  wire logic                   rst_n_in,
  // dictionary transfers
  input  wire homing_pkg::dict_req_t  req_in,
  output homing_pkg::dict_rsp_t       rsp_out,
  // non-volatile store
  input  wire logic                   nv_valid_in,
  input  wire logic [7:0]             nv_value_in,
  output logic                        nv_write_out,
  output logic [7:0]                  nv_value_out,
  // ram parameter write
  output logic                        param_write_out,
  output logic [15:0]                 param_number_out,
  output logic [2:0]                  param_dataset_out,
  output logic [7:0]                  param_value_out,
  output logic [7:0]                  method_out,
  // run control
  input  wire logic                   start_in,
  input  wire logic [31:0]            home_offset_in,
  // switch and encoder pins
  input  wire logic                   travel_end_neg_in,
  input  wire logic                   travel_end_pos_in,
  input  wire logic                   origin_switch_in,
  input  wire logic                   encoder_index_pulse_in,
  // motion results
  output logic                        drive_pos_out,
  output logic                        drive_neg_out,
  output logic                        busy_out,
  output logic                        done_out,
  output logic                        fault_out,
  output logic                        set_position_out,
  output logic [31:0]                 position_value_out
);

  // ---------------------------------------------------------------
  // kind of procedure a method code selects
  // ---------------------------------------------------------------
  function automatic homing_pkg::kind_t kind_of(input logic [7:0] m);
    logic [7:0] b;
    b = m;
    if (m >= homing_pkg::M_DIRECT_LO && m <= homing_pkg::M_DIRECT_HI) begin
      b = m - homing_pkg::M_DIRECT_OFS;  // [RL10]
    end
    if (m == homing_pkg::M_NONE) begin
      kind_of = homing_pkg::K_NONE;
    end else if (b < homing_pkg::M_HSW_LO) begin
      kind_of = homing_pkg::K_LIM;
    end else if (b <= homing_pkg::M_HSW_HI) begin
      kind_of = homing_pkg::K_HSW;
    end else if (b <= homing_pkg::M_SCAN_HI) begin
      kind_of = homing_pkg::K_SCAN;
    end else if (m == homing_pkg::M_IDX_NEG || m == homing_pkg::M_IDX_POS) begin
      kind_of = homing_pkg::K_IDX;
    end else if (m == homing_pkg::M_HERE) begin
      kind_of = homing_pkg::K_HERE;
    end else begin
      kind_of = homing_pkg::K_BAD;  // [RL14]
    end
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisation and edges
  // ---------------------------------------------------------------
  logic [3:0] pins_s;
  logic       lim_neg;
  logic       lim_pos;
  logic       sw;
  logic       idx;
  logic       sw_d_r;
  logic       idx_d_r;

  pin_sync #(.WIDTH(4)) u_sync (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .pins_in  ({travel_end_neg_in, travel_end_pos_in, origin_switch_in,
                encoder_index_pulse_in}),
    .sync_out (pins_s)
  );

  assign lim_neg = pins_s[3];
  assign lim_pos = pins_s[2];
  assign sw      = pins_s[1];
  assign idx     = pins_s[0];

  // ---------------------------------------------------------------
  // dictionary and store side
  // ---------------------------------------------------------------
  logic                  boot_r;
  logic [7:0]            method_r;
  homing_pkg::dict_rsp_t rsp_nxt;
  logic                  take;
  logic                  hit_method;
  logic                  hit_store;
  logic                  wr_ok;

  assign take       = req_in.valid && !boot_r;
  assign hit_method = req_in.index == homing_pkg::IDX_METHOD
                      && req_in.sub == homing_pkg::SUB_METHOD;
  assign hit_store  = req_in.index == homing_pkg::IDX_STORE && req_in.sub == homing_pkg::SUB_STORE
                      && req_in.write;
  assign wr_ok      = req_in.write && hit_method && kind_of(req_in.data) != homing_pkg::K_BAD;

  // answer for the request taken this cycle
  always_comb begin
    rsp_nxt       = '0;
    rsp_nxt.valid = take;
    rsp_nxt.index = req_in.index;
    rsp_nxt.sub   = req_in.sub;
    if (hit_method && !req_in.write) begin
      rsp_nxt.cmd  = homing_pkg::CMD_UPLOAD_1B;  // [RL13]
      rsp_nxt.data = {24'h00_0000, method_r};
    end else if (wr_ok || hit_store) begin
      rsp_nxt.cmd  = homing_pkg::CMD_DOWNLOAD_ACK;  // [RL13]
    end else if (hit_method) begin
      rsp_nxt.cmd  = homing_pkg::CMD_ABORT;
      rsp_nxt.data = homing_pkg::ABORT_RANGE;  // [RL14]
    end else begin
      rsp_nxt.cmd  = homing_pkg::CMD_ABORT;
      rsp_nxt.data = homing_pkg::ABORT_NO_OBJECT;
    end
  end

  // restore wins the first cycle; requests in that cycle are ignored and get no answer
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boot_r            <= 1'b1;
      method_r          <= homing_pkg::METHOD_RESET;  // [RL1]
      rsp_out           <= '0;
      nv_write_out      <= 1'b0;
      nv_value_out      <= homing_pkg::METHOD_RESET;
      param_write_out   <= 1'b0;
      param_number_out  <= homing_pkg::PARAM_HOMING_MODE;
      param_dataset_out <= homing_pkg::PARAM_DATASET;
      param_value_out   <= homing_pkg::METHOD_RESET;
    end else begin
      boot_r          <= 1'b0;
      rsp_out         <= rsp_nxt;
      nv_write_out    <= take && hit_store;  // [RL3]
      nv_value_out    <= method_r;
      param_write_out <= 1'b0;
      if (boot_r && nv_valid_in) begin
        method_r        <= nv_value_in;  // [RL4]
        param_write_out <= 1'b1;
        param_value_out <= nv_value_in;
      end else if (take && wr_ok) begin
        method_r        <= req_in.data;
        param_write_out <= 1'b1;  // [RL2]
        param_value_out <= req_in.data;
      end
    end
  end
  assign method_out = method_r;

  // ---------------------------------------------------------------
  // method decode; a run works on the code latched at its start
  // ---------------------------------------------------------------
  homing_pkg::run_state_t st_r;
  homing_pkg::run_state_t st_nxt;
  homing_pkg::kind_t      kind;
  logic [7:0]             run_m_r;
  logic [7:0]             dec_m;
  logic [7:0]             base_m;
  logic                   use_index;
  logic                   final_pos;
  logic                   want_rise;
  logic                   dir0_pos;
  logic                   edge_hit;
  logic                   lim_ahead;
  logic                   dir_pos_r;
  logic                   rev_r;

  assign dec_m     = (st_r == homing_pkg::ST_IDLE) ? method_r : run_m_r;
  assign kind      = kind_of(dec_m);
  assign use_index = !(dec_m >= homing_pkg::M_DIRECT_LO && dec_m <= homing_pkg::M_DIRECT_HI);
  assign base_m    = use_index ? dec_m : dec_m - homing_pkg::M_DIRECT_OFS;  // [RL10]
  assign final_pos = homing_pkg::FINAL_POS_MASK[base_m[3:0]];
  // moving positive the left edge rises; moving negative the right edge rises
  assign want_rise = dir_pos_r ^ homing_pkg::RIGHT_EDGE_MASK[base_m[3:0]];
  assign lim_ahead = dir_pos_r ? lim_pos : lim_neg;

  // first direction: toward the switch edge or the chosen limit
  assign dir0_pos = (kind == homing_pkg::K_LIM)  ? (base_m == homing_pkg::M_LIM_POS) :  // [RL6]
    (kind == homing_pkg::K_HSW)  ? ((base_m <= homing_pkg::M_HSW_POS_HI) ^ sw) :  // [RL7]
    (kind == homing_pkg::K_SCAN) ? (base_m <= homing_pkg::M_SCAN_POS_HI) :  // [RL8] [RL9]
    (dec_m == homing_pkg::M_IDX_POS);  // [RL11]

  // home-switch kinds take any edge; scan kinds only the chosen one
  assign edge_hit = (kind == homing_pkg::K_HSW)  ? (sw != sw_d_r) :
    (kind == homing_pkg::K_SCAN) ? (want_rise ? (sw && !sw_d_r) : (!sw && sw_d_r)) :
    1'b0;

  // ---------------------------------------------------------------
  // run sequencer
  // ---------------------------------------------------------------
  logic dir_nxt;
  logic rev_nxt;
  logic done_nxt;
  logic fault_nxt;
  logic setp_nxt;

  always_comb begin
    st_nxt    = st_r;
    dir_nxt   = dir_pos_r;
    rev_nxt   = rev_r;
    done_nxt  = 1'b0;
    fault_nxt = 1'b0;
    setp_nxt  = 1'b0;
    case (st_r)
      homing_pkg::ST_IDLE: begin
        if (start_in && !boot_r) begin
          rev_nxt = 1'b0;
          dir_nxt = dir0_pos;
          case (kind)
            homing_pkg::K_NONE: begin
              done_nxt = 1'b1;  // [RL5]
            end
            homing_pkg::K_HERE: begin
              setp_nxt = 1'b1;  // [RL12]
              done_nxt = 1'b1;
            end
            homing_pkg::K_IDX: begin
              st_nxt = homing_pkg::ST_FINE;  // [RL11]
            end
            homing_pkg::K_BAD: begin
              fault_nxt = 1'b1;
            end
            default: begin
              st_nxt = homing_pkg::ST_SEEK;
            end
          endcase
        end
      end
      homing_pkg::ST_SEEK: begin
        if ((kind == homing_pkg::K_LIM && lim_ahead) || edge_hit) begin
          if (use_index) begin
            st_nxt  = homing_pkg::ST_FINE;  // [RL6] [RL7]
            dir_nxt = final_pos;
          end else begin
            st_nxt   = homing_pkg::ST_IDLE;  // [RL10]
            setp_nxt = 1'b1;
            done_nxt = 1'b1;
          end
        end else if (lim_ahead) begin
          if (kind == homing_pkg::K_SCAN && !rev_r) begin
            dir_nxt = !dir_pos_r;  // [RL8] [RL9]
            rev_nxt = 1'b1;
          end else begin
            st_nxt    = homing_pkg::ST_IDLE;
            fault_nxt = 1'b1;
          end
        end
      end
      homing_pkg::ST_FINE: begin
        if (idx && !idx_d_r) begin
          st_nxt   = homing_pkg::ST_IDLE;  // [RL6] [RL11]
          setp_nxt = 1'b1;
          done_nxt = 1'b1;
        end else if (lim_ahead) begin
          st_nxt    = homing_pkg::ST_IDLE;  // no index before the end of travel
          fault_nxt = 1'b1;
        end
      end
      default: begin
        st_nxt = homing_pkg::ST_IDLE;
      end
    endcase
  end

  // state and registered motion outputs
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r               <= homing_pkg::ST_IDLE;
      run_m_r            <= homing_pkg::METHOD_RESET;
      dir_pos_r          <= 1'b0;
      rev_r              <= 1'b0;
      sw_d_r             <= 1'b0;
      idx_d_r            <= 1'b0;
      drive_pos_out      <= 1'b0;
      drive_neg_out      <= 1'b0;
      busy_out           <= 1'b0;
      done_out           <= 1'b0;
      fault_out          <= 1'b0;
      set_position_out   <= 1'b0;
      position_value_out <= 32'h0000_0000;
    end else begin
      st_r             <= st_nxt;
      dir_pos_r        <= dir_nxt;
      rev_r            <= rev_nxt;
      sw_d_r           <= sw;
      idx_d_r          <= idx;
      drive_pos_out    <= (st_nxt != homing_pkg::ST_IDLE) && dir_nxt;
      drive_neg_out    <= (st_nxt != homing_pkg::ST_IDLE) && !dir_nxt;
      busy_out         <= st_nxt != homing_pkg::ST_IDLE;
      done_out         <= done_nxt;
      fault_out        <= fault_nxt;
      set_position_out <= setp_nxt;
      if (st_r == homing_pkg::ST_IDLE) begin
        run_m_r <= method_r;
      end
      if (setp_nxt) begin
        position_value_out <= home_offset_in;  // [RL12]
      end
    end
  end

endmodule

`default_nettype wire

// >>> tb/dict_master.sv
/*
  Fieldbus master model: one-byte expedited dictionary transfers.
  Assumes the selector answers one cycle after it takes a request.
*/
`timescale 1ns/1ps
`default_nettype none

module dict_master (
  // clock
  input  wire logic                  mclk_in,
  // dictionary request and answer
  output var  homing_pkg::dict_req_t req_out,
  input  wire homing_pkg::dict_rsp_t rsp_in
);
  // ---------------------------------------------------------------
  // transfer task
  // ---------------------------------------------------------------
  initial req_out = '0;

  // one-cycle request; idle fields inverted so stale data never looks fresh
  task automatic xfer(input int gap, input logic wr, input logic [15:0] idx,
                      input logic [7:0] sb, input logic [7:0] d,
                      output homing_pkg::dict_rsp_t r, output logic ok);
    int n;
    repeat (gap) @(posedge mclk_in);
    @(posedge mclk_in);
    req_out <= '{valid: 1'b1, write: wr, index: idx, sub: sb, data: d};
    @(posedge mclk_in);
    req_out <= {1'b0, ~req_out[32:0]};
    #1;
    for (n = 0; n < 4 && rsp_in.valid !== 1'b1; n++) begin
      @(posedge mclk_in);
      #1;
    end
    r = rsp_in;
    ok = (rsp_in.valid === 1'b1);
  endtask
endmodule

`default_nettype wire

// >>> tb/homing_method_selector_props.sv
/*
  Checker of the homing method selector, bound to its top module.
  Assumes the dictionary and run timing of the designer's hand-over.
*/
`timescale 1ns/1ps
`default_nettype none

module homing_method_selector_props (
  // clock and reset
  input wire logic                  mclk_in,
  input wire logic                  rst_n_in,
  // dictionary, store and parameter
  input wire homing_pkg::dict_req_t req_in,
  input wire homing_pkg::dict_rsp_t rsp_out,
  input wire logic                  nv_write_out,
  input wire logic [7:0]            nv_value_out,
  input wire logic                  param_write_out,
  input wire logic [15:0]           param_number_out,
  input wire logic [2:0]            param_dataset_out,
  input wire logic [7:0]            param_value_out,
  input wire logic [7:0]            method_out,
  // run
  input wire logic                  start_in,
  input wire logic [31:0]           home_offset_in,
  input wire logic                  drive_pos_out,
  input wire logic                  drive_neg_out,
  input wire logic                  busy_out,
  input wire logic                  done_out,
  input wire logic                  set_position_out,
  input wire logic [31:0]           position_value_out
);
  // ---------------------------------------------------------------
  // helper decode
  // ---------------------------------------------------------------
  logic booted_r;
  wire [7:0] wd = req_in.data;
  wire legal = wd <= 8'h0e || (wd >= 8'h11 && wd <= 8'h1e) || (wd >= 8'h21 && wd <= 8'h23);
  wire take = req_in.valid && booted_r;
  wire at_m = req_in.index == homing_pkg::IDX_METHOD && req_in.sub == homing_pkg::SUB_METHOD;
  wire at_s = req_in.index == homing_pkg::IDX_STORE && req_in.sub == homing_pkg::SUB_STORE;
  wire wr_m = take && req_in.write && at_m;
  wire go = start_in && !busy_out && booted_r;

  // first edge after release is the restore cycle, which ignores requests
  always_ff @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in) booted_r <= 1'b0;
    else booted_r <= 1'b1;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  chk_answer_next: assert property (
    take |=> rsp_out.valid) else $error("request not answered");
  chk_write_mirror: assert property (
    wr_m && legal |=> param_write_out && param_value_out == $past(wd) && method_out == $past(wd)
      && rsp_out.cmd == homing_pkg::CMD_DOWNLOAD_ACK) else $error("write not mirrored");
  chk_bad_reject: assert property (
    wr_m && !legal |=> rsp_out.data == homing_pkg::ABORT_RANGE && !param_write_out
      && $stable(method_out)) else $error("bad method accepted");
  chk_read_answer: assert property (
    take && !req_in.write && at_m |=> rsp_out.cmd == homing_pkg::CMD_UPLOAD_1B
      && rsp_out.data == {24'h0, $past(method_out)}) else $error("bad read answer");
  chk_store_commit: assert property (
    take && req_in.write && at_s |=> nv_write_out && nv_value_out == $past(method_out))
    else $error("store not committed");
  chk_unknown_obj: assert property (
    take && !at_m && !(req_in.write && at_s) |=> rsp_out.cmd == homing_pkg::CMD_ABORT
      && rsp_out.data == homing_pkg::ABORT_NO_OBJECT) else $error("unknown object answered");
  chk_param_target: assert property (
    param_write_out |-> param_number_out == 16'h046a && param_dataset_out == 3'h5)
    else $error("wrong parameter target");
  chk_none_still: assert property (
    go && method_out == homing_pkg::M_NONE |=> done_out && !set_position_out && !drive_pos_out
      && !drive_neg_out && $stable(position_value_out)) else $error("method zero moved");
  chk_here_load: assert property (
    go && method_out == homing_pkg::M_HERE |=> set_position_out && done_out
      && position_value_out == $past(home_offset_in)) else $error("offset not loaded");
  chk_index_dir: assert property (
    go && method_out == homing_pkg::M_IDX_POS |=> busy_out && drive_pos_out ##0 !drive_neg_out[*1])
    else $error("index search direction");

  // main scenarios reached
  cover property (wr_m && legal);
  cover property (go && method_out == homing_pkg::M_IDX_NEG);
  cover property (nv_write_out);
  cover property (done_out && set_position_out && !busy_out);
endmodule

bind homing_method_selector homing_method_selector_props u_props (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .req_in(req_in), .rsp_out(rsp_out),
  .nv_write_out(nv_write_out), .nv_value_out(nv_value_out),
  .param_write_out(param_write_out), .param_number_out(param_number_out),
  .param_dataset_out(param_dataset_out), .param_value_out(param_value_out),
  .method_out(method_out), .start_in(start_in), .home_offset_in(home_offset_in),
  .drive_pos_out(drive_pos_out), .drive_neg_out(drive_neg_out), .busy_out(busy_out),
  .done_out(done_out), .set_position_out(set_position_out),
  .position_value_out(position_value_out));

`default_nettype wire

// >>> tb/testbench.sv
/*
  Self-checking bench: method object access, store, restore and runs.
  Assumes the dictionary master model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ---------------------------------------------------------------
  // bench state and design
  // ---------------------------------------------------------------
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  wire homing_pkg::dict_req_t req;
  wire homing_pkg::dict_rsp_t rsp;
  homing_pkg::dict_rsp_t r;
  logic nv_valid = 1'b0, start = 1'b0, ok, seen;
  logic [7:0] nv_value = 8'h00, exp_m = 8'h00, nv_out, param_value, method;
  logic nv_write, param_write, busy, done, fault, set_pos, dpos, dneg;
  logic [15:0] param_number;
  logic [2:0] param_dataset;
  logic [31:0] offset = 32'h0, pos_value;
  logic [3:0] pins = 4'h0; // index, origin, positive end, negative end
  int fail_count = 0, comparisons = 0;

  always #12.5 mclk_in = ~mclk_in;
  homing_method_selector u_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .req_in(req), .rsp_out(rsp),
    .nv_valid_in(nv_valid), .nv_value_in(nv_value), .nv_write_out(nv_write),
    .nv_value_out(nv_out), .param_write_out(param_write), .param_number_out(param_number),
    .param_dataset_out(param_dataset), .param_value_out(param_value), .method_out(method),
    .start_in(start), .home_offset_in(offset), .travel_end_neg_in(pins[0]),
    .travel_end_pos_in(pins[1]), .origin_switch_in(pins[2]), .encoder_index_pulse_in(pins[3]),
    .drive_pos_out(dpos), .drive_neg_out(dneg), .busy_out(busy), .done_out(done),
    .fault_out(fault), .set_position_out(set_pos), .position_value_out(pos_value));

  dict_master u_master (.mclk_in(mclk_in), .req_out(req), .rsp_in(rsp));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic legal(input logic [7:0] v);
    return v <= 8'd14 || (v >= 8'd17 && v <= 8'd30) || (v >= 8'd33 && v <= 8'd35);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge mclk_in);
    #1;
  endtask

  // a lost answer ends the run at once, since later checks would be noise
  task automatic dict(input logic wr, input logic [15:0] idx, input logic [7:0] sb,
                      input logic [7:0] d);
    u_master.xfer($urandom % 2, wr, idx, sb, d, r, ok);
    check({31'h0, ok}, 32'h1);
    if (ok !== 1'b1) end_of_test();
  endtask

  task automatic wr_method(input logic [7:0] v);
    dict(1'b1, homing_pkg::IDX_METHOD, homing_pkg::SUB_METHOD, v);
    if (legal(v)) exp_m = v;
    check(r.data, legal(v) ? 32'h0 : homing_pkg::ABORT_RANGE);
    check(32'({param_write, param_value}), 32'({legal(v), exp_m}));
    check(32'({param_number, param_dataset, method}), 32'({16'd1130, 3'd5, exp_m}));
  endtask

  task automatic rd_method();
    dict(1'b0, homing_pkg::IDX_METHOD, homing_pkg::SUB_METHOD, 8'h00);
    check({r.index, r.sub, r.cmd}, {16'h6098, 8'h00, 8'h4f});
    check(r.data, {24'h00_0000, exp_m});
  endtask

  // script: p/n wait for direction, a-d raise and A-D drop a pin, w waits,
  // h/f/z expect home, fault or a run without motion
  task automatic run(input logic [7:0] m, input string s);
    logic [31:0] prev;
    byte c;
    int k;
    prev = pos_value;
    wr_method(m);
    @(posedge mclk_in);
    start <= 1'b1;
    offset <= $urandom;
    @(posedge mclk_in);
    start <= 1'b0;
    #1;
    for (int i = 0; i < s.len(); i++) begin
      c = s[i];
      case (c)
        "p", "n": begin
          for (k = 0; k < 8 && {dpos, dneg} !== {c == "p", c == "n"}; k++) tick();
          check(32'({dpos, dneg}), 32'({c == "p", c == "n"}));
          if (k == 8) end_of_test();
        end
        "w": repeat (4) tick();
        "h", "f", "z": begin
          for (k = 0; k < 12 && (done | fault) !== 1'b1; k++) tick();
          check(32'({fault, done, set_pos}), 32'({c == "f", c != "f", c == "h"}));
          if (c != "f") check(pos_value, c == "h" ? offset : prev);
          if (k == 12) end_of_test();
        end
        default: begin
          @(posedge mclk_in);
          pins[c[1:0] - 2'd1] <= c[5];
          #1;
        end
      endcase
    end
    @(posedge mclk_in);
    pins <= 4'h0;
    repeat (4) tick();
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(86));
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (2) tick();
    check(32'(method), 32'h0000_0000);
    for (int i = 0; i < 300; i++) begin
      wr_method(i < 256 ? i[7:0] : 8'($urandom));
      rd_method();
    end
    dict(1'b0, homing_pkg::IDX_STORE, homing_pkg::SUB_STORE, 8'h00);
    check(r.data, homing_pkg::ABORT_NO_OBJECT);
    dict(1'b1, homing_pkg::IDX_METHOD, 8'h01, 8'h05);
    check(r.data, homing_pkg::ABORT_NO_OBJECT);
    check(32'(method), 32'(exp_m));
    wr_method(8'h17);
    dict(1'b1, homing_pkg::IDX_STORE, homing_pkg::SUB_STORE, 8'($urandom));
    check(32'({nv_write, nv_out}), 32'h0000_0117);
    @(posedge mclk_in);
    nv_valid <= 1'b1;
    nv_value <= 8'h0b;
    rst_n_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    seen = 1'b0;
    repeat (3) begin
      tick();
      seen = seen | param_write;
    end
    exp_m = 8'h0b;
    check(32'({seen, method}), 32'({1'b1, exp_m}));
    rd_method();
    run(8'h00, "z");
    run(8'h23, "h");
    run(8'h22, "pdh");
    run(8'h21, "ndh");
    run(8'h01, "napAdh");
    run(8'h02, "pbnBdh");
    run(8'h03, "pcndh");
    run(8'h05, "ncpdh");
    run(8'h07, "pbnBcwCwdh");
    run(8'h0b, "ncpdh");
    run(8'h0c, "napAbf");
    run(8'h11, "nah");
    run(8'h12, "pbh");
    run(8'h13, "pch");
    end_of_test();
  end
endmodule

`default_nettype wire
